// [rfi_defines.svh]
// Constants for the regulator fault interrupt block: register offsets,
// field positions, reset values and timing counts.
// Assumes a 50 MHz system clock shared by both ends of the link.
`ifndef RFI_DEFINES_SVH
`define RFI_DEFINES_SVH

`define RFI_NREG 4
`define RFI_AW 4
`define RFI_DW 8

// Device register offsets on the link
`define RFI_OFS_TOP1 4'h0
`define RFI_OFS_TOP2 4'h1
`define RFI_OFS_REGEVT 4'h2
`define RFI_OFS_PGEVT 4'h3
`define RFI_OFS_MASK_TOP 4'h4
`define RFI_OFS_MASK_REG 4'h5
`define RFI_OFS_STAT 4'h6
`define RFI_OFS_PGSTAT 4'h7
`define RFI_OFS_GPIO_IN 4'h8
`define RFI_OFS_REG_EN 4'h9
`define RFI_OFS_GPIO_CTRL 4'hA

// Field positions in TOP1, TOP2 and the top-level mask
`define RFI_B_WARN 0
`define RFI_B_SD 1
`define RFI_B_OVP 2
`define RFI_B_GPIO 3
`define RFI_B_CLK 4
`define RFI_B_MEAS 5
`define RFI_B_RESTART_MASK 6
`define RFI_B_RESTART 0

// Reset values
`define RFI_EN_RST 4'hF
`define RFI_MASK_RST 8'h00
`define RFI_RESTART_RST 1'b1

// Timing
`define RFI_CLK_MHZ 50
`define RFI_OC_DEBOUNCE_US 20
`define RFI_SC_DEBOUNCE_MS 1
`define RFI_OC_CYCLES (`RFI_OC_DEBOUNCE_US * `RFI_CLK_MHZ)
`define RFI_SC_CYCLES (`RFI_SC_DEBOUNCE_MS * 1000 * `RFI_CLK_MHZ)

// Host APB register offsets
`define RFI_APB_CMD 8'h00
`define RFI_APB_STATUS 8'h04
`define RFI_APB_INT_STATUS 8'h08
`define RFI_APB_INT_CLEAR 8'h0C
`define RFI_APB_INT_ENABLE 8'h10
`define RFI_CMD_WR_BIT 16
`define RFI_INT_DONE 0
`define RFI_INT_DEVIRQ 1

`endif

// [rfi_pkg.sv]
// Types shared by both ends of the regulator fault interrupt link.
// Assumes rfi_defines.svh for widths.
`include "rfi_defines.svh"
package rfi_pkg;
   typedef logic [`RFI_AW-1:0] rfi_addr_t;
   typedef logic [`RFI_DW-1:0] rfi_data_t;
   typedef enum logic {RFI_IDLE, RFI_WAIT} rfi_host_state_t;
endpackage

// [rfi_link_if.sv]
// Link between the regulator fault device and its host controller:
// interrupt line plus a held-request register port.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface rfi_link_if;
   import rfi_pkg::*;
   logic irq_n_output;
   logic req;
   logic wr;
   rfi_addr_t addr;
   rfi_data_t wdata;
   logic ack;
   rfi_data_t rdata;
   modport dev (output irq_n_output, output ack, output rdata,
                input req, input wr, input addr, input wdata);
   modport host (input irq_n_output, input ack, input rdata,
                 output req, output wr, output addr, output wdata);
endinterface

// [rfi_device.sv]
// Regulator fault interrupt device end: sticky event flags, masks, live
// status, protection trips and the active-low interrupt line.
// Assumes analog detector levels arrive asynchronously on the *_in pins.
//
// Implementation choices: the held-request register port and the register offsets.
`timescale 1ns/100ps
`include "rfi_defines.svh"

// Overview of operation
// [R1] Any condition sets its flag, pulls line low
// [R2] Line stays low until all pending cleared
// [R3] Whole-device shutdown reports restart flag afterwards
// [R4] Protection disables one regulator, faults all
// [R5] Current limit debounced 20 us sets flags
// [R6] Overcurrent clear ignored while limit active
// [R7] Output low 1 ms sets short flag
// [R8] Thermal warning flag held while hot
// [R9] Thermal shutdown flag held while hot
// [R10] Overvoltage flag held while supply high
// [R11] Shutdown disables regulators, drives output pins low
// [R12] Power-good reached sets maskable flag
// [R13] Pin edge sets maskable pin event flag
// [R14] Sync clock change sets clock event flag
// [R15] Measurement done sets ready flag
// [R16] Start-up without rising output trips regulator
// [R17] Reset sets maskable restart flag, write-one clears
// [R18] Masked flag records but never interrupts
// [R19] Writing zero leaves flags unchanged
module rfi_device #(
   parameter int SC_CYCLES = `RFI_SC_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // Link to host
   rfi_link_if.dev link,
   // Analog detector levels, one per regulator
   input wire logic [`RFI_NREG-1:0] ilim_in,
   input wire logic [`RFI_NREG-1:0] vout_ok_in,
   input wire logic [`RFI_NREG-1:0] pg_reached_in,
   // Device-wide detector levels and events
   input wire logic temp_warn_in,
   input wire logic temp_sd_in,
   input wire logic analog_supply_ov_in,
   input wire logic sync_clk_present_in,
   input wire logic iload_done_in,
   // General-purpose pins
   input wire logic [3:0] gpio_in,
   output logic [3:0] gpio_out,
   output logic [3:0] gpio_oe_out,
   // Regulator enables
   output logic [`RFI_NREG-1:0] reg_en_out
);
   import rfi_pkg::*;

   localparam int NR = `RFI_NREG;
   localparam int OC_CYCLES = `RFI_OC_CYCLES;
   localparam int SW = 21;

   logic [SW-1:0] raw, sy1_reg, sy2_reg;
   logic [3:0] ilim_s, vok_s, pg_s, gpio_s;
   logic warn_s, sd_s, ov_s, sclk_s, ild_s;
   logic [9:0] prev_reg;
   logic [5:0] top1_reg;
   logic restart_reg;
   logic [3:0] oc_reg, sc_reg, pg_reg;
   logic [6:0] mask_top_reg;
   logic [7:0] mask_reg_reg;
   logic [3:0] en_reg, tripped_reg, gpio_dir_reg, gpio_val_reg;
   logic shut_reg, restart_evt;
   logic [3:0] oc_live, sc_evt, pg_rise;
   logic [5:0] top_set;
   logic take, any_pend, ack_reg, irq_n_reg;
   rfi_data_t rdata_reg, rd_mux;
   rfi_data_t clr_top1, clr_top2, clr_evt, clr_pg;

   // Write-one clear mask for a register, zero when not addressed
   function automatic rfi_data_t w1c(input rfi_addr_t ofs);
      w1c = (take && link.wr && link.addr == ofs) ? link.wdata : '0; // [R19]
   endfunction

   function automatic logic hit(input rfi_addr_t ofs);
      hit = take && link.wr && link.addr == ofs;
   endfunction

   assign clr_top1 = w1c(`RFI_OFS_TOP1);
   assign clr_top2 = w1c(`RFI_OFS_TOP2);
   assign clr_evt = w1c(`RFI_OFS_REGEVT);
   assign clr_pg = w1c(`RFI_OFS_PGEVT);

   // Detector inputs are asynchronous to clk_sys_in
   assign raw = {gpio_in, iload_done_in, sync_clk_present_in, analog_supply_ov_in,
                 temp_sd_in, temp_warn_in, pg_reached_in, vout_ok_in, ilim_in};
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         sy1_reg <= '0;
         sy2_reg <= '0;
      end else begin
         sy1_reg <= raw;
         sy2_reg <= sy1_reg;
      end
   end
   assign ilim_s = sy2_reg[3:0];
   assign vok_s = sy2_reg[7:4];
   assign pg_s = sy2_reg[11:8];
   assign warn_s = sy2_reg[12];
   assign sd_s = sy2_reg[13];
   assign ov_s = sy2_reg[14];
   assign sclk_s = sy2_reg[15];
   assign ild_s = sy2_reg[16];
   assign gpio_s = sy2_reg[20:17];

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= {gpio_s, ild_s, sclk_s, pg_s};
      end
   end
   assign pg_rise = pg_s & ~prev_reg[3:0];

   // Per-regulator debouncers
   genvar i;
   generate
      for (i = 0; i < NR; i++) begin : g_reg
         logic [9:0] oc_cnt_reg;
         logic [15:0] sc_cnt_reg;
         logic running;
         assign running = en_reg[i] & ~tripped_reg[i] & ~shut_reg;
         always_ff @(posedge clk_sys_in) begin
            if (rst_in || !ilim_s[i]) begin
               oc_cnt_reg <= '0;
            end else if (oc_cnt_reg != 10'(OC_CYCLES)) begin
               oc_cnt_reg <= oc_cnt_reg + 10'h001; // [R5]
            end
         end
         assign oc_live[i] = (oc_cnt_reg == 10'(OC_CYCLES)); // [R5]
         // One counter covers both the start-up window and operation
         always_ff @(posedge clk_sys_in) begin
            if (rst_in || !running || vok_s[i]) begin
               sc_cnt_reg <= '0;
            end else if (sc_cnt_reg != 16'(SC_CYCLES)) begin
               sc_cnt_reg <= sc_cnt_reg + 16'h0001; // [R7] [R16]
            end
         end
         assign sc_evt[i] = running && (sc_cnt_reg == 16'(SC_CYCLES)); // [R7] [R16]
      end
   endgenerate

   // Protection trips only the affected regulator; re-writing enable re-arms
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         tripped_reg <= '0;
      end else if (restart_evt) begin
         tripped_reg <= '0;
      end else begin
         tripped_reg <= (tripped_reg & ~(hit(`RFI_OFS_REG_EN) ? link.wdata[3:0] : 4'h0))
                        | sc_evt; // [R4] [R16]
      end
   end

   // Fault shutdown held while either fault level persists
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         shut_reg <= 1'b0;
      end else begin
         shut_reg <= sd_s | ov_s; // [R4] [R11]
      end
   end
   assign restart_evt = shut_reg & ~sd_s & ~ov_s;

   assign reg_en_out = shut_reg ? 4'h0 : (en_reg & ~tripped_reg); // [R4] [R11]
   assign gpio_out = shut_reg ? 4'h0 : gpio_val_reg; // [R11]
   assign gpio_oe_out = gpio_dir_reg;

   // Live levels are set terms, so a clear cannot win while they hold
   assign top_set[`RFI_B_WARN] = warn_s; // [R8]
   assign top_set[`RFI_B_SD] = sd_s; // [R9]
   assign top_set[`RFI_B_OVP] = ov_s; // [R10]
   assign top_set[`RFI_B_GPIO] = |(gpio_s ^ prev_reg[9:6]); // [R13]
   assign top_set[`RFI_B_CLK] = sclk_s ^ prev_reg[4]; // [R14]
   assign top_set[`RFI_B_MEAS] = ild_s & ~prev_reg[5]; // [R15]

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         top1_reg <= '0;
      end else begin
         top1_reg <= (top1_reg & ~clr_top1[5:0]) | top_set; // [R1]
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         restart_reg <= `RFI_RESTART_RST; // [R17]
      end else begin
         restart_reg <= (restart_reg & ~clr_top2[`RFI_B_RESTART])
                        | restart_evt; // [R3] [R17]
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         oc_reg <= '0;
         sc_reg <= '0;
         pg_reg <= '0;
      end else begin
         oc_reg <= (oc_reg & ~clr_evt[3:0]) | oc_live; // [R5] [R6]
         sc_reg <= (sc_reg & ~clr_evt[7:4]) | sc_evt; // [R7]
         pg_reg <= (pg_reg & ~clr_pg[3:0]) | pg_rise; // [R12]
      end
   end

   // Control registers; shutdown and overvoltage masks are fixed at zero
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         mask_top_reg <= 7'(`RFI_MASK_RST);
         mask_reg_reg <= `RFI_MASK_RST;
         en_reg <= `RFI_EN_RST;
         gpio_dir_reg <= '0;
         gpio_val_reg <= '0;
      end else begin
         if (hit(`RFI_OFS_MASK_TOP)) begin
            mask_top_reg <= link.wdata[6:0] & 7'h79;
         end
         if (hit(`RFI_OFS_MASK_REG)) begin
            mask_reg_reg <= link.wdata;
         end
         if (hit(`RFI_OFS_REG_EN)) begin
            en_reg <= link.wdata[3:0];
         end
         if (hit(`RFI_OFS_GPIO_CTRL)) begin
            gpio_val_reg <= link.wdata[3:0];
            gpio_dir_reg <= link.wdata[7:4];
         end
      end
   end

   always_comb begin
      unique case (link.addr)
         `RFI_OFS_TOP1: rd_mux = {2'b00, top1_reg};
         `RFI_OFS_TOP2: rd_mux = {oc_reg | sc_reg | pg_reg, 3'b000, restart_reg};
         `RFI_OFS_REGEVT: rd_mux = {sc_reg, oc_reg};
         `RFI_OFS_PGEVT: rd_mux = {4'h0, pg_reg};
         `RFI_OFS_MASK_TOP: rd_mux = {1'b0, mask_top_reg};
         `RFI_OFS_MASK_REG: rd_mux = mask_reg_reg;
         `RFI_OFS_STAT: rd_mux = {sclk_s, ov_s, sd_s, warn_s, oc_live};
         `RFI_OFS_PGSTAT: rd_mux = {4'h0, pg_s};
         `RFI_OFS_GPIO_IN: rd_mux = {4'h0, gpio_s}; // [R13]
         `RFI_OFS_REG_EN: rd_mux = {tripped_reg, en_reg};
         `RFI_OFS_GPIO_CTRL: rd_mux = {gpio_dir_reg, gpio_val_reg};
         default: rd_mux = '0;
      endcase
   end

   // A request is taken once; ack pulses the cycle after
   assign take = link.req & ~ack_reg;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ack_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         ack_reg <= take;
         if (take) begin
            rdata_reg <= rd_mux;
         end
      end
   end
   assign link.ack = ack_reg;
   assign link.rdata = rdata_reg;

   // Mask bit set means the flag is recorded but kept off the line
   assign any_pend = |(top1_reg & ~mask_top_reg[5:0]) // [R18]
                     | (restart_reg & ~mask_top_reg[`RFI_B_RESTART_MASK])
                     | |(oc_reg & ~mask_reg_reg[3:0])
                     | |sc_reg
                     | |(pg_reg & ~mask_reg_reg[7:4]);
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         irq_n_reg <= 1'b1;
      end else begin
         irq_n_reg <= ~any_pend; // [R1] [R2]
      end
   end
   assign link.irq_n_output = irq_n_reg;

endmodule // rfi_device

// [rfi_host.sv]
// Host end of the regulator fault link: APB slave with command,
// status and interrupt registers; runs one device register access at a time.
// Assumes software clears device flags by writing ones through CMD.
`timescale 1ns/100ps
`include "rfi_defines.svh"
module rfi_host (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Interrupt to the processor
   output logic irq_out,
   // Link to device
   rfi_link_if.host link
);
   import rfi_pkg::*;

   rfi_host_state_t state_reg;
   logic req_reg, wr_reg, irq_prev_reg;
   rfi_addr_t addr_reg;
   rfi_data_t wdata_reg, rdata_reg;
   logic [1:0] int_st_reg, int_en_reg;
   logic [31:0] prdata_reg;
   logic access, mapped, cmd_wr, done_evt, devirq_evt;

   function automatic logic apb_wr(input logic [7:0] ofs);
      apb_wr = access && pwrite_in && paddr_in == ofs;
   endfunction

   assign access = psel_in & penable_in;
   assign mapped = paddr_in == `RFI_APB_CMD || paddr_in == `RFI_APB_STATUS
                   || paddr_in == `RFI_APB_INT_STATUS || paddr_in == `RFI_APB_INT_CLEAR
                   || paddr_in == `RFI_APB_INT_ENABLE;
   assign pready_out = 1'b1;
   assign pslverr_out = access & ~mapped;
   assign cmd_wr = apb_wr(`RFI_APB_CMD) && state_reg == RFI_IDLE;
   assign done_evt = state_reg == RFI_WAIT && link.ack;
   // Device line is produced on this clock, so no synchroniser
   assign devirq_evt = ~link.irq_n_output & ~irq_prev_reg;

   // Read data sampled in the setup cycle, presented in the access phase
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         prdata_reg <= '0;
      end else if (psel_in && !penable_in) begin
         unique case (paddr_in)
            `RFI_APB_STATUS: prdata_reg <= {16'h0000, rdata_reg, 6'h00,
                                           ~link.irq_n_output, state_reg == RFI_WAIT};
            `RFI_APB_INT_STATUS: prdata_reg <= {30'h0, int_st_reg};
            `RFI_APB_INT_ENABLE: prdata_reg <= {30'h0, int_en_reg};
            default: prdata_reg <= '0;
         endcase
      end
   end
   assign prdata_out = prdata_reg;

   // Commands arriving while busy are dropped
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state_reg <= RFI_IDLE;
         req_reg <= 1'b0;
         wr_reg <= 1'b0;
         addr_reg <= '0;
         wdata_reg <= '0;
         rdata_reg <= '0;
      end else begin
         unique case (state_reg)
            RFI_IDLE: begin
               if (cmd_wr) begin
                  req_reg <= 1'b1;
                  wr_reg <= pwdata_in[`RFI_CMD_WR_BIT];
                  addr_reg <= pwdata_in[11:8];
                  wdata_reg <= pwdata_in[7:0]; // [R6] [R13] [R17]
                  state_reg <= RFI_WAIT;
               end
            end
            RFI_WAIT: begin
               if (link.ack) begin
                  req_reg <= 1'b0;
                  rdata_reg <= link.rdata;
                  state_reg <= RFI_IDLE;
               end
            end
         endcase
      end
   end
   assign link.req = req_reg;
   assign link.wr = wr_reg;
   assign link.addr = addr_reg;
   assign link.wdata = wdata_reg;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         irq_prev_reg <= 1'b0;
         int_st_reg <= '0;
         int_en_reg <= '0;
      end else begin
         irq_prev_reg <= ~link.irq_n_output;
         int_st_reg <= (int_st_reg & ~(apb_wr(`RFI_APB_INT_CLEAR) ? pwdata_in[1:0] : 2'b00))
                       | {devirq_evt, done_evt};
         if (apb_wr(`RFI_APB_INT_ENABLE)) begin
            int_en_reg <= pwdata_in[1:0];
         end
      end
   end
   assign irq_out = |(int_st_reg & int_en_reg);

endmodule // rfi_host

// [rfi_asserts.sv]
// Concurrent checks on the device-host link: handshake and interrupt line.
// Assumes one clock and a synchronous active-high reset shared by both ends.
`timescale 1ns/100ps
module rfi_asserts (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // Link signals
   input wire logic irq_n_output,
   input wire logic req,
   input wire logic wr,
   input wire rfi_pkg::rfi_addr_t addr,
   input wire rfi_pkg::rfi_data_t wdata,
   input wire logic ack,
   input wire rfi_pkg::rfi_data_t rdata
);
   import rfi_pkg::*;
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   a_ack_after_take: assert property (req && !ack |=> ack)
      else $error("no ack after a taken request");
   a_ack_one_cycle: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   a_ack_needs_req: assert property (ack |-> req && $past(req))
      else $error("ack without a request");
   a_req_held_steady: assert property (req && !ack |=> req && $stable(addr) && $stable(wr)
      && $stable(wdata))
      else $error("request changed before ack");
   a_req_drops: assert property (ack |=> !req)
      else $error("request not dropped after ack");
   a_rdata_on_ack: assert property (!$stable(rdata) |-> ack)
      else $error("read data changed outside an answer");
   a_restart_irq_low: assert property ($fell(rst_in) |=> !irq_n_output)
      else $error("interrupt line not low after reset");
   a_release_by_write: assert property ($rose(irq_n_output) |-> $past(ack && wr))
      else $error("interrupt line released without a write");

   c_write_done: cover property (ack && wr);
   c_read_done: cover property (ack && !wr);
   c_irq_release: cover property ($rose(irq_n_output));
endmodule // rfi_asserts

// [test_regulator_fault_interrupt.sv]
// Self-checking bench: device and host joined by the link, driven over APB.
// Assumes a 50 MHz clock and a shortened short-circuit debounce.
`timescale 1ns/100ps
`include "rfi_defines.svh"
module test_regulator_fault_interrupt;
   import rfi_pkg::*;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, irq;
   logic [3:0] ilim = 4'h0, vout_ok = 4'hF, pg = 4'h0, gpio_i = 4'h0;
   logic twarn = 1'b0, tsd = 1'b0, ovp = 1'b0, sclk = 1'b0, iload = 1'b0;
   logic [3:0] gpio_o, gpio_oe, reg_en;
   logic [7:0] q8;
   int mismatches = 0;
   int checked = 0;

   always #10 clk_sys_in = ~clk_sys_in;

   rfi_link_if u_rfi_link_if ();
   // Short debounce keeps the run short; expectations use the same figure
   rfi_device #(.SC_CYCLES(20)) u_rfi_device (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .link(u_rfi_link_if), .ilim_in(ilim), .vout_ok_in(vout_ok), .pg_reached_in(pg),
      .temp_warn_in(twarn), .temp_sd_in(tsd), .analog_supply_ov_in(ovp),
      .sync_clk_present_in(sclk), .iload_done_in(iload), .gpio_in(gpio_i),
      .gpio_out(gpio_o), .gpio_oe_out(gpio_oe), .reg_en_out(reg_en));
   rfi_host u_rfi_host (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
      .link(u_rfi_link_if));
   rfi_asserts u_rfi_asserts (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .irq_n_output(u_rfi_link_if.irq_n_output), .req(u_rfi_link_if.req),
      .wr(u_rfi_link_if.wr), .addr(u_rfi_link_if.addr), .wdata(u_rfi_link_if.wdata),
      .ack(u_rfi_link_if.ack), .rdata(u_rfi_link_if.rdata));

   task stop_test;
      $display("Checks %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         mismatches++;
         stop_test;
      end
   endtask

   // Device access through the command register, then poll until idle
   task dev(input logic w, input logic [3:0] a, input logic [7:0] d);
      logic [31:0] r;
      int n;
      n = 0;
      apb(1'b1, `RFI_APB_CMD, {15'h0000, w, 4'h0, a, d}, r);
      r = 32'h1;
      while (r[0] !== 1'b0 && n < 20) begin
         apb(1'b0, `RFI_APB_STATUS, 32'h0, r);
         n++;
      end
      if (r[0] !== 1'b0) begin
         mismatches++;
         stop_test;
      end
      q8 = r[15:8];
   endtask

   task wr(input logic [3:0] a, input logic [7:0] d);
      dev(1'b1, a, d);
   endtask

   task rd(input string name, input logic [3:0] a, input logic [7:0] exp);
      dev(1'b0, a, 8'h00);
      chk(name, {24'h0, exp}, {24'h0, q8});
   endtask

   task irqn(input logic exp);
      tick(3);
      chk("irq_n", {31'h0, exp}, {31'h0, u_rfi_link_if.irq_n_output});
   endtask

   task t_reset;
      logic [31:0] q;
      irqn(1'b0);
      apb(1'b0, `RFI_APB_INT_STATUS, 32'h0, q);
      chk("int_status", 32'h2, q);
      apb(1'b1, `RFI_APB_INT_ENABLE, 32'h2, q);
      tick(2);
      chk("irq_out", 32'h1, {31'h0, irq});
      apb(1'b1, `RFI_APB_INT_CLEAR, 32'h2, q);
      tick(2);
      chk("irq_out", 32'h0, {31'h0, irq});
      apb(1'b0, 8'h40, 32'h0, q);
      chk("pslverr", 32'h1, {31'h0, err});
      rd("top2", `RFI_OFS_TOP2, 8'h01);
      apb(1'b0, `RFI_APB_INT_STATUS, 32'h0, q);
      chk("int_status", 32'h1, q);
      rd("reg_en", `RFI_OFS_REG_EN, 8'h0F);
      chk("reg_en_out", 32'hF, {28'h0, reg_en});
      rd("unmapped", 4'hF, 8'h00);
      wr(`RFI_OFS_TOP2, 8'h00);
      rd("top2", `RFI_OFS_TOP2, 8'h01);
      wr(`RFI_OFS_TOP2, 8'h01);
      irqn(1'b1);
   endtask

   // Edge events: pin change, sync clock change, measurement done
   task t_events;
      for (int b = 3; b <= 5; b++) begin
         @(posedge clk_sys_in);
         case (b)
            3: gpio_i <= 4'h5;
            4: sclk <= 1'b1;
            default: iload <= 1'b1;
         endcase
         tick(6);
         iload <= 1'b0;
         irqn(1'b0);
         rd("top1", `RFI_OFS_TOP1, 8'h01 << b);
         wr(`RFI_OFS_TOP1, 8'h00);
         rd("top1", `RFI_OFS_TOP1, 8'h01 << b);
         wr(`RFI_OFS_TOP1, 8'h01 << b);
         rd("top1", `RFI_OFS_TOP1, 8'h00);
         irqn(1'b1);
      end
   endtask

   // Level conditions: warning, thermal shutdown, supply overvoltage
   task t_levels;
      wr(`RFI_OFS_GPIO_CTRL, 8'hFF);
      tick(2);
      chk("gpio_out", 32'hF, {28'h0, gpio_o});
      chk("gpio_oe_out", 32'hF, {28'h0, gpio_oe});
      for (int b = 0; b <= 2; b++) begin
         @(posedge clk_sys_in);
         twarn <= (b == 0);
         tsd <= (b == 1);
         ovp <= (b == 2);
         tick(6);
         rd("top1", `RFI_OFS_TOP1, 8'h01 << b);
         wr(`RFI_OFS_TOP1, 8'h01 << b);
         rd("top1", `RFI_OFS_TOP1, 8'h01 << b);
         if (b != 0) begin
            chk("reg_en_out", 32'h0, {28'h0, reg_en});
            chk("gpio_out", 32'h0, {28'h0, gpio_o});
         end
         twarn <= 1'b0;
         tsd <= 1'b0;
         ovp <= 1'b0;
         tick(6);
         wr(`RFI_OFS_TOP1, 8'h01 << b);
         rd("top1", `RFI_OFS_TOP1, 8'h00);
         if (b != 0) begin
            rd("top2", `RFI_OFS_TOP2, 8'h01);
            wr(`RFI_OFS_TOP2, 8'h01);
            wr(`RFI_OFS_REG_EN, 8'h0F);
         end
         irqn(1'b1);
      end
   endtask

   task t_mask;
      wr(`RFI_OFS_MASK_TOP, 8'hFF);
      rd("mask_top", `RFI_OFS_MASK_TOP, 8'h79);
      wr(`RFI_OFS_MASK_TOP, 8'h20);
      @(posedge clk_sys_in);
      iload <= 1'b1;
      tick(6);
      iload <= 1'b0;
      rd("top1", `RFI_OFS_TOP1, 8'h20);
      irqn(1'b1);
      wr(`RFI_OFS_MASK_TOP, 8'h00);
      irqn(1'b0);
      wr(`RFI_OFS_TOP1, 8'h20);
      irqn(1'b1);
   endtask

   task t_overcurrent;
      @(posedge clk_sys_in);
      ilim <= 4'h1;
      tick(900);
      ilim <= 4'h0;
      tick(6);
      rd("regevt", `RFI_OFS_REGEVT, 8'h00);
      ilim <= 4'h1;
      tick(1010);
      rd("regevt", `RFI_OFS_REGEVT, 8'h01);
      // Sync clock was left present by the event scenario, so its live bit shows
      rd("stat", `RFI_OFS_STAT, 8'h81);
      rd("top2", `RFI_OFS_TOP2, 8'h10);
      wr(`RFI_OFS_REGEVT, 8'h01);
      rd("regevt", `RFI_OFS_REGEVT, 8'h01);
      ilim <= 4'h0;
      tick(6);
      wr(`RFI_OFS_REGEVT, 8'h01);
      rd("regevt", `RFI_OFS_REGEVT, 8'h00);
      irqn(1'b1);
   endtask

   task t_short;
      @(posedge clk_sys_in);
      vout_ok <= 4'hD;
      tick(30);
      rd("regevt", `RFI_OFS_REGEVT, 8'h20);
      chk("reg_en_out", 32'hD, {28'h0, reg_en});
      rd("top2", `RFI_OFS_TOP2, 8'h20);
      vout_ok <= 4'hF;
      wr(`RFI_OFS_REGEVT, 8'h20);
      rd("regevt", `RFI_OFS_REGEVT, 8'h00);
      wr(`RFI_OFS_REG_EN, 8'h0F);
      tick(2);
      chk("reg_en_out", 32'hF, {28'h0, reg_en});
   endtask

   task t_power_good;
      wr(`RFI_OFS_MASK_REG, 8'h40);
      rd("mask_reg", `RFI_OFS_MASK_REG, 8'h40);
      @(posedge clk_sys_in);
      pg <= 4'h4;
      tick(6);
      irqn(1'b1);
      rd("pgevt", `RFI_OFS_PGEVT, 8'h04);
      rd("pgstat", `RFI_OFS_PGSTAT, 8'h04);
      rd("top2", `RFI_OFS_TOP2, 8'h40);
      wr(`RFI_OFS_MASK_REG, 8'h00);
      irqn(1'b0);
      rd("gpio_in", `RFI_OFS_GPIO_IN, 8'h05);
      wr(`RFI_OFS_PGEVT, 8'h04);
      rd("pgevt", `RFI_OFS_PGEVT, 8'h00);
      irqn(1'b1);
   endtask

   initial begin
      tick(16);
      rst_in <= 1'b0;
      tick(4);
      t_reset;
      t_events;
      t_levels;
      t_mask;
      t_overcurrent;
      t_short;
      t_power_good;
      stop_test;
   end
endmodule // test_regulator_fault_interrupt
